// *** ststr_top.sv ***
// Self-test status reporter: fault capture, self tests, display digit encoding
//
// What this block does
// - Left digit: processor 1, sensor 2, master-loss 4
// - Right digit: printer 1, link 2, recovery 4
// - Group 1: loopback 1, timeout 2, carrier 4
// - Group 2: processor 1, checksum 2, memory 4
// - Group 3: paper 1, offline 2, fault 4
// - Group 4: output loopback 1, master loss 4
// - Sensor group: resets 1, counter 2, loopback 4
// - Group 6: sensor processor, program, data memory
// - Group 7: converter, heater driver, temperature sensor
// - Group 8: calibration range, pressure, power supply
// - Group 9: long recovery, no response, CRC
// - Processor test failure sets status bit 0
// - Program memory sum mismatch sets bit 1
// - Data memory 55/AA test, save and restore
// - Link first character mismatch sets bit 4
// - No poll for five seconds sets bit 5
// - Three bad CRC messages set bit 6
// - Distribution output loopback mismatch sets bit 8
// - Printer status sampled at print start
// - Processor test: FF, minus 55, AA, flags
// - General display flashes until acknowledged
// - Lamp check plus clear enters detailed mode
module ststr_top
  import ststr_pkg::*;
#(
  parameter longint TMO_CYC = STSTR_TMO_CYC,
  parameter logic [21:0] FLASH_CYC = STSTR_FLASH_CYC
)(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_tx_first,
  input wire logic [7:0] link_tx_char,
  input wire logic [7:0] link_rx_char,
  input wire logic link_poll_seen,
  input wire logic link_msg_done,
  input wire logic link_crc_bad,
  input wire logic link_carrier_tmo,
  input wire logic wdo_tx_first,
  input wire logic [7:0] wdo_tx_char,
  input wire logic [7:0] wdo_rx_char,
  input wire logic print_start,
  input wire logic [2:0] printer_stat,
  input wire logic indicator_check_input,
  input wire logic status_clear_input,
  output logic [2:0] gen_left_digit,
  output logic [2:0] gen_right_digit,
  output logic gen_blank,
  output logic detail_mode
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] status;
    logic [4:0] ctrl;
    logic [23:0] sensor;
    logic [15:0] romsum;
    logic [2:0] printer;
    logic [1:0] crc_cnt;
    logic [25:0] tmo_cnt;
    logic [21:0] flash_cnt;
    logic flash_ph;
    logic acked;
    logic [5:0] last_code;
    logic [2:0] gl;
    logic [2:0] gr;
    logic blank;
    logic detail;
    logic [1:0] chk_s1;
    logic [1:0] chk_s2;
    logic clr_prev;
    ststr_state_t st;
    logic [3:0] idx;
    logic [15:0] sum;
    logic [7:0] save;
    logic [STSTR_ROM_WORDS-1:0][7:0] rom;
    logic [STSTR_RAM_WORDS-1:0][7:0] ram;
  } ststr_reg_t;

  ststr_reg_t s_q, s_d;

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Weighted 3-bit digit from three flags
  function automatic logic [2:0] wdig(input logic w1, input logic w2, input logic w4);
    wdig = {w4, w2, w1};
  endfunction

  // Program memory window, one byte in the low lane of each word
  function automatic logic in_rom(input logic [7:0] a);
    in_rom = (a[7:6] == 2'b01);
  endfunction

  // Data memory window, one byte in the low lane of each word
  function automatic logic in_ram(input logic [7:0] a);
    in_ram = (a[7:5] == 3'b100);
  endfunction

  // Addresses whose writes answer without an error response
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= STSTR_OFS_CRCCNT) || in_rom(a) || in_ram(a);
  endfunction

  // Checksum with one more program byte added, wrapping at 16 bits
  function automatic logic [15:0] add_byte(input logic [15:0] s, input logic [7:0] b);
    add_byte = s + {8'h00, b};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic [7:0] cpu_a;
  logic [7:0] cpu_c;
  logic [8:0] cpu_d;
  logic cpu_ok;
  logic link_err;
  logic sens_err;
  logic [2:0] gl_n;
  logic [2:0] gr_n;
  logic wr;
  logic rd;
  logic clr_rise;
  logic [15:0] ev_set;

  always_comb
  begin
    s_d = s_q;
    // Events gather in an empty word so a clear cannot swallow one
    s_d.status = 16'h0000;
    // Processor exercise: 0x7f + 0x80 = FF, FF - 55 = AA, AA + 55 = FF
    cpu_a = 8'h7f + 8'h80;
    cpu_c = cpu_a - STSTR_PAT_A;
    cpu_d = {1'b0, cpu_c} + {1'b0, STSTR_PAT_A};
    cpu_ok = (cpu_a == STSTR_ALL_ONES) && (cpu_c == STSTR_PAT_B) &&
             (cpu_d[7:0] == STSTR_ALL_ONES) && (cpu_d[7:0] != 8'h00) &&
             cpu_d[7] && !cpu_d[8]; // Zero, sign and carry
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    clr_rise = s_q.chk_s2[1] && !s_q.clr_prev;
    s_d.clr_prev = s_q.chk_s2[1];
    s_d.chk_s1 = {status_clear_input, indicator_check_input};
    s_d.chk_s2 = s_q.chk_s1;
    s_d.pready = psel && !penable;
    s_d.pslverr = 1'b0;

    // Self-test sequencer, runs while enabled
    case (s_q.st)
      // Waits for the run bit; clearing it stops tests only between passes
      ST_IDLE:
      begin
        if (s_q.ctrl[STSTR_CTL_RUN])
          s_d.st = ST_CPU;
      end
      // Result of the fixed arithmetic exercise, then start the checksum
      ST_CPU:
      begin
        if (!cpu_ok)
          s_d.status[STSTR_BIT_CPU] = 1'b1;
        s_d.st = ST_ROM;
        s_d.idx = 4'd0;
        s_d.sum = 16'h0000;
      end
      // One program byte per cycle into the running sum
      ST_ROM:
      begin
        s_d.sum = add_byte(s_q.sum, s_q.rom[s_q.idx]); // 16-bit running sum
        s_d.idx = s_q.idx + 4'd1;
        if (s_q.idx == 4'(STSTR_ROM_WORDS - 1))
        begin
          if (add_byte(s_q.sum, s_q.rom[s_q.idx]) != s_q.romsum)
            s_d.status[STSTR_BIT_ROM] = 1'b1;
          s_d.st = ST_RAM_SAVE;
          s_d.idx = 4'd0;
        end
      end
      // Save the location and lay down the first pattern
      ST_RAM_SAVE:
      begin
        // One location per round of four states; bus writes to data memory are dropped meanwhile
        s_d.save = s_q.ram[s_q.idx[2:0]];
        s_d.ram[s_q.idx[2:0]] = STSTR_PAT_A;
        s_d.st = ST_RAM_A;
      end
      // Check the first pattern and lay down the second
      ST_RAM_A:
      begin
        if (s_q.ram[s_q.idx[2:0]] != STSTR_PAT_A)
          s_d.status[STSTR_BIT_RAM] = 1'b1;
        s_d.ram[s_q.idx[2:0]] = STSTR_PAT_B;
        s_d.st = ST_RAM_B;
      end
      // Check the second pattern
      ST_RAM_B:
      begin
        if (s_q.ram[s_q.idx[2:0]] != STSTR_PAT_B)
          s_d.status[STSTR_BIT_RAM] = 1'b1;
        s_d.st = ST_RAM_REST;
      end
      // Put the saved byte back and step to the next location
      ST_RAM_REST:
      begin
        s_d.ram[s_q.idx[2:0]] = s_q.save; // Restore contents
        s_d.idx = s_q.idx + 4'd1;
        s_d.st = (s_q.idx == 4'(STSTR_RAM_WORDS - 1)) ? ST_IDLE : ST_RAM_SAVE;
      end
      default:
        s_d.st = ST_IDLE;
    endcase

    // Loopback compares on first character
    if (link_tx_first && (link_tx_char != link_rx_char))
      s_d.status[STSTR_BIT_LOOP] = 1'b1;
    if (wdo_tx_first && (wdo_tx_char != wdo_rx_char))
      s_d.status[STSTR_BIT_WDO] = 1'b1;
    // Carrier loss from the link receiver is latched as it comes
    if (link_carrier_tmo)
      s_d.status[STSTR_BIT_CARR] = 1'b1;

    // Poll timeout counter
    // The count stops one past the limit so a long silence cannot wrap
    if (link_poll_seen)
      s_d.tmo_cnt = 26'd0;
    else if (s_q.tmo_cnt <= 26'(TMO_CYC))
      s_d.tmo_cnt = s_q.tmo_cnt + 26'd1;
    if (s_q.tmo_cnt > 26'(TMO_CYC))
      s_d.status[STSTR_BIT_TMO] = 1'b1;

    // Bad CRC counter, saturating at the limit
    // Saturating keeps a burst of bad messages from wrapping to zero
    if (link_msg_done && link_crc_bad && (s_q.crc_cnt != STSTR_CRC_LIMIT))
      s_d.crc_cnt = s_q.crc_cnt + 2'd1;
    if (s_q.crc_cnt >= STSTR_CRC_LIMIT)
      s_d.status[STSTR_BIT_CRC] = 1'b1;

    // Printer status sampled at each print start
    if (print_start)
      s_d.printer = printer_stat;

    // Merge this cycle's events into the sticky word
    ev_set = s_d.status;
    s_d.status = s_q.status | ev_set;

    // APB access; status clear is write-one-to-clear, a new event wins
    if (wr)
    begin
      if (paddr == STSTR_OFS_STATUS)
        s_d.status = (s_q.status & ~pwdata[15:0]) | ev_set;
      else if (paddr == STSTR_OFS_CTRL)
        s_d.ctrl = pwdata[4:0];
      else if (paddr == STSTR_OFS_SENSOR)
        s_d.sensor = pwdata[23:0];
      else if (paddr == STSTR_OFS_ROMSUM)
        s_d.romsum = pwdata[15:0];
      else if (paddr == STSTR_OFS_CRCCNT)
        s_d.crc_cnt = 2'd0;
      else if (in_rom(paddr))
        s_d.rom[paddr[5:2]] = pwdata[7:0];
      else if (in_ram(paddr) && (s_q.st == ST_IDLE)) // Closed during a pass
        s_d.ram[paddr[4:2]] = pwdata[7:0];
    end

    // General digits
    // Weight 1 of the left digit covers processor tests and the link loop test
    link_err = s_q.status[STSTR_BIT_TMO] | s_q.status[STSTR_BIT_CRC] |
               s_q.status[STSTR_BIT_CARR] | s_q.sensor[22];
    sens_err = |s_q.sensor;
    gl_n = wdig(|s_q.status[4:0], sens_err, s_q.ctrl[STSTR_CTL_MASTER_LOST]);
    gr_n = wdig(s_q.ctrl[STSTR_CTL_RECORDER] & (|s_q.printer), link_err,
                s_q.ctrl[STSTR_CTL_RECOVERY]);
    s_d.gl = gl_n;
    s_d.gr = gr_n;

    // Flash on new code until acknowledged
    // The phase runs free; only the acknowledge is tied to the code
    if (s_q.flash_cnt == FLASH_CYC)
    begin
      s_d.flash_cnt = 22'd0;
      s_d.flash_ph = !s_q.flash_ph;
    end
    else
      s_d.flash_cnt = s_q.flash_cnt + 22'd1;
    if ({gl_n, gr_n} != s_q.last_code)
      s_d.acked = 1'b0;
    else if (clr_rise && !s_q.chk_s2[0])
      s_d.acked = 1'b1;
    s_d.last_code = {gl_n, gr_n};
    s_d.blank = ({gl_n, gr_n} != 6'd0) && !s_q.acked && s_q.flash_ph;

    // Detailed mode toggles on clear pressed while lamp check held
    // Lamp check alone does nothing; only the clear press acts
    if (clr_rise && s_q.chk_s2[0])
      s_d.detail = !s_q.detail;

    // Read data mux, detailed groups packed into the display register
    s_d.prdata = 32'h0000_0000;
    if (rd)
    begin
      if (paddr == STSTR_OFS_STATUS)
        s_d.prdata = {16'h0000, s_q.status};
      else if (paddr == STSTR_OFS_CTRL)
        s_d.prdata = {27'h0, s_q.ctrl};
      else if (paddr == STSTR_OFS_DISP)
        s_d.prdata = {5'h00,
          s_q.sensor[23:21], // Group 9
          s_q.sensor[20:18], // Group 8
          s_q.sensor[17:15], // Group 7
          s_q.sensor[14:12], // Group 6
          s_q.sensor[11:9], // Sensor group
          wdig(s_q.status[STSTR_BIT_WDO], 1'b0, s_q.ctrl[STSTR_CTL_MASTER_LOST]),
          wdig(s_q.printer[0], s_q.printer[1], s_q.printer[2]),
          wdig(s_q.status[0], s_q.status[1], s_q.status[2]),
          wdig(s_q.status[4], s_q.status[5], s_q.status[7])};
      else if (paddr == STSTR_OFS_SENSOR)
        s_d.prdata = {8'h00, s_q.sensor};
      else if (paddr == STSTR_OFS_ROMSUM)
        s_d.prdata = {16'h0000, s_q.romsum};
      else if (paddr == STSTR_OFS_CRCCNT)
        s_d.prdata = {30'h0, s_q.crc_cnt};
      else if (in_rom(paddr))
        s_d.prdata = {24'h0, s_q.rom[paddr[5:2]]};
      else if (in_ram(paddr))
        s_d.prdata = {24'h0, s_q.ram[paddr[4:2]]};
      else
        s_d.pslverr = 1'b1;
    end
    // Writes to holes are refused at setup too, answered with the ready
    else if (psel && !penable && !mapped(paddr))
      s_d.pslverr = 1'b1;
    if (!(psel && !penable))
      s_d.pslverr = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register stage
  // Reset loads every field, the memories included, with constants
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.status <= STSTR_STATUS_RST;
      s_q.romsum <= STSTR_ROMSUM_RST;
      s_q.ctrl <= STSTR_CTRL_RST;
      s_q.st <= ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops, so pins never see decode glitches
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign gen_left_digit = s_q.gl;
  assign gen_right_digit = s_q.gr;
  assign gen_blank = s_q.blank;
  assign detail_mode = s_q.detail;

endmodule

// *** ststr_pkg.sv ***
// Package of constants and types for the self-test status reporter
package ststr_pkg;
  // APB register byte offsets
  localparam logic [7:0] STSTR_OFS_STATUS = 8'h00;
  localparam logic [7:0] STSTR_OFS_CTRL = 8'h04;
  localparam logic [7:0] STSTR_OFS_DISP = 8'h08;
  localparam logic [7:0] STSTR_OFS_SENSOR = 8'h0c;
  localparam logic [7:0] STSTR_OFS_ROMSUM = 8'h10;
  localparam logic [7:0] STSTR_OFS_CRCCNT = 8'h14;
  // Unit status word bit positions
  localparam int STSTR_BIT_CPU = 0;
  localparam int STSTR_BIT_ROM = 1;
  localparam int STSTR_BIT_RAM = 2;
  localparam int STSTR_BIT_LOOP = 4;
  localparam int STSTR_BIT_TMO = 5;
  localparam int STSTR_BIT_CRC = 6;
  localparam int STSTR_BIT_CARR = 7;
  localparam int STSTR_BIT_WDO = 8;
  // Control register bit positions
  localparam int STSTR_CTL_RUN = 0;
  localparam int STSTR_CTL_RECORDER = 1;
  localparam int STSTR_CTL_MASTER_LOST = 2;
  localparam int STSTR_CTL_RECOVERY = 3;
  localparam int STSTR_CTL_LONG_REC = 4;
  // Reset values and sizes
  localparam logic [15:0] STSTR_STATUS_RST = 16'h0000;
  localparam logic [15:0] STSTR_ROMSUM_RST = 16'h0000;
  localparam logic [4:0] STSTR_CTRL_RST = 5'h01;
  localparam int STSTR_ROM_WORDS = 16;
  localparam int STSTR_RAM_WORDS = 8;
  localparam logic [7:0] STSTR_PAT_A = 8'h55;
  localparam logic [7:0] STSTR_PAT_B = 8'haa;
  localparam logic [7:0] STSTR_ALL_ONES = 8'hff;
  localparam logic [1:0] STSTR_CRC_LIMIT = 2'd3;
  // Link timeout: five seconds at 10 MHz
  localparam longint STSTR_TMO_SEC = 5;
  localparam longint STSTR_CLK_HZ = 10000000;
  localparam longint STSTR_TMO_CYC = STSTR_TMO_SEC * STSTR_CLK_HZ;
  // Flash half-period of the status display
  localparam logic [21:0] STSTR_FLASH_CYC = 22'd2500000;
  // Self-test sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_CPU, ST_ROM, ST_RAM_SAVE, ST_RAM_A, ST_RAM_B,
    ST_RAM_REST} ststr_state_t;
endpackage

// *** ststr_props.sv ***
// Checker for the status reporter: bus timing and status encoding
module ststr_props
  import ststr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic link_tx_first,
  input wire logic [7:0] link_tx_char,
  input wire logic [7:0] link_rx_char,
  input wire logic [2:0] gen_left_digit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Bus answers one cycle after setup, for one cycle only
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("ready missing");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmap; psel && !penable && paddr inside {[8'h18:8'h3c]} |=> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("hole not refused");
  property p_map; psel && !penable && !pwrite && paddr <= 8'h14 |=> !pslverr; endproperty
  a_map: assert property (p_map) else $error("register refused");
  ////////////////////////////////////////
  // Unassigned status and code positions always read zero
  property p_st; pready && !pwrite && paddr == STSTR_OFS_STATUS |-> !prdata[3] && prdata[31:9] == 0; endproperty
  a_st: assert property (p_st) else $error("status spare bit set");
  property p_det; pready && !pwrite && paddr == STSTR_OFS_DISP |-> !prdata[10] && prdata[31:27] == 0; endproperty
  a_det: assert property (p_det) else $error("unassigned code shown");
  // A failed loopback shows in the left digit within four cycles
  property p_loop; link_tx_first && link_tx_char != link_rx_char |-> ##[1:4] gen_left_digit[0]; endproperty
  a_loop: assert property (p_loop) else $error("loop fault not shown");
endmodule

bind ststr_top ststr_props u_props (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .link_tx_first, .link_tx_char, .link_rx_char, .gen_left_digit);

// *** ststr_peer.sv ***
// Far-side model: periodic polls and echo of the first link character
module ststr_peer
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic quiet,
  input wire logic corrupt,
  input wire logic link_tx_first,
  input wire logic [7:0] link_tx_char,
  output logic link_poll_seen,
  output logic [7:0] link_rx_char
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_q;
  // Poll interval counter, well inside the shortened timeout
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      cnt_q <= 6'h0;
    else
      cnt_q <= (cnt_q == 6'h27) ? 6'h0 : cnt_q + 6'h1;
  assign link_poll_seen = !quiet && cnt_q == 6'h27;
  // Echo while the first character is on the line (inverted when corrupt), else a changed value
  assign link_rx_char = link_tx_first ? link_tx_char ^ {8{corrupt}} : ~link_tx_char;
endmodule

// *** testbench.sv ***
// Testbench for the self-test status reporter
module testbench
  import ststr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, rerr, link_poll_seen;
  logic link_crc_bad, quiet, corrupt, lamp, clr, gen_blank, detail_mode;
  logic [4:0] ev, c;
  logic [7:0] paddr, link_tx_char, link_rx_char, wdo_tx_char, wdo_rx_char, b;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] printer_stat, p, pr, gen_left_digit, gen_right_digit;
  logic [15:0] st, sum;
  logic [23:0] sn;
  logic [7:0] mem [8];
  int errors, compares;
  ststr_top #(.TMO_CYC(100), .FLASH_CYC(22'd50)) u_dut (.sys_clk, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_tx_first(ev[0]), .link_tx_char,
    .link_rx_char, .link_poll_seen, .link_msg_done(ev[1]), .link_crc_bad,
    .link_carrier_tmo(ev[2]), .wdo_tx_first(ev[3]), .wdo_tx_char, .wdo_rx_char,
    .print_start(ev[4]), .printer_stat, .indicator_check_input(lamp),
    .status_clear_input(clr), .gen_left_digit, .gen_right_digit, .gen_blank, .detail_mode);
  ststr_peer u_peer (.sys_clk, .rstn, .quiet, .corrupt, .link_tx_first(ev[0]),
    .link_tx_char, .link_poll_seen, .link_rx_char);
  ////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    results;
  end
  ////////////////////////////////////////
  // Compare, bus cycle, event pulse
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Hold the access phase until the slave answers; only the watchdog ends a hang
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task pls(input logic [4:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 5'h0;
  endtask
  // Expected detailed code word
  function automatic logic [31:0] det();
    return {5'h0, sn[23:9], c[2], 1'b0, st[8], pr, st[2:0], st[7], st[5], st[4]};
  endfunction
  task check;
    repeat (300) @(posedge sys_clk);
    rd(STSTR_OFS_STATUS, {16'h0, st});
    rd(STSTR_OFS_DISP, det());
    chk(32'(gen_left_digit), 32'({c[2], |sn[23:9], |st[4:0]}));
    chk(32'(gen_right_digit), 32'({c[3], |st[7:5] | sn[22], c[1] & |pr}));
  endtask
  ////////////////////////////////////////
  // One round of fault events, each checked as it accumulates
  task round;
    c = 5'($urandom) | 5'h01;
    sn = 24'($urandom) & 24'hfffe00;
    p = 3'($urandom);
    b = 8'($urandom);
    apb(1'b1, STSTR_OFS_CTRL, 32'(c));
    apb(1'b1, STSTR_OFS_SENSOR, 32'(sn));
    link_tx_char <= 8'($urandom);
    corrupt <= 1'b0;
    pls(5'h01);
    check;
    corrupt <= 1'b1;
    pls(5'h01);
    st[4] = 1'b1;
    check;
    quiet <= 1'b1;
    repeat (150) @(posedge sys_clk);
    quiet <= 1'b0;
    st[5] = 1'b1;
    check;
    link_crc_bad <= 1'b0;
    pls(5'h02);
    link_crc_bad <= 1'b1;
    repeat (2) pls(5'h02);
    check;
    pls(5'h02);
    st[6] = 1'b1;
    rd(STSTR_OFS_CRCCNT, 32'h3);
    check;
    wdo_tx_char <= b;
    wdo_rx_char <= b;
    pls(5'h08);
    pls(5'h04);
    st[7] = 1'b1;
    check;
    wdo_rx_char <= ~b;
    pls(5'h08);
    st[8] = 1'b1;
    check;
    printer_stat <= p;
    pls(5'h10);
    printer_stat <= ~p;
    pr = p;
    check;
    apb(1'b1, STSTR_OFS_CRCCNT, 32'h0);
    apb(1'b1, STSTR_OFS_STATUS, 32'h1ff);
    st = 16'h0;
    check;
  endtask
  task press(input logic l, input logic e);
    lamp <= l;
    clr <= 1'b1;
    repeat (6) @(posedge sys_clk);
    clr <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(32'(detail_mode), 32'(e));
  endtask
  // Watch the blank output over two flash phases
  task blink(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (120) @(posedge sys_clk) seen |= gen_blank;
    chk(32'(seen), 32'(e));
  endtask
  task results;
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rstn, psel, penable, pwrite, ev, quiet, corrupt, lamp, clr, link_crc_bad} = '0;
    {paddr, pwdata, link_tx_char, wdo_tx_char, wdo_rx_char, printer_stat} = '0;
    {errors, compares, st, sn, pr, sum} = '0;
    c = 5'h01;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    void'($urandom(77));
    rd(STSTR_OFS_CTRL, 32'(STSTR_CTRL_RST));
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, STSTR_OFS_CTRL, 32'h0);
    repeat (60) @(posedge sys_clk); // Let a running pass finish
    for (int i = 0; i < 16; i++)
    begin
      b = 8'($urandom);
      sum += 16'(b);
      mem[i % 8] = ~b;
      apb(1'b1, 8'(8'h40 + 4 * i), 32'(b));
      apb(1'b1, 8'(8'h80 + 4 * (i % 8)), 32'(mem[i % 8]));
    end
    apb(1'b1, STSTR_OFS_ROMSUM, 32'(sum + 16'h1));
    apb(1'b1, STSTR_OFS_CTRL, 32'h1);
    st = 16'h2;
    check;
    apb(1'b1, STSTR_OFS_ROMSUM, 32'(sum));
    apb(1'b1, STSTR_OFS_STATUS, 32'h2);
    st = 16'h0;
    check;
    apb(1'b1, STSTR_OFS_CTRL, 32'h0);
    repeat (60) @(posedge sys_clk); // Let a running pass finish
    for (int i = 0; i < 8; i++)
      rd(8'(8'h80 + 4 * i), 32'(mem[i]));
    repeat (4) round;
    press(1'b1, 1'b1);
    apb(1'b1, STSTR_OFS_SENSOR, 32'h200);
    blink(1'b1);
    press(1'b0, 1'b1);
    blink(1'b0);
    chk(32'(gen_left_digit), 32'({c[2], 2'b10}));
    press(1'b1, 1'b0);
    results;
  end
endmodule
